// *** src/cdc_pkg.sv ***
// Purpose: Shared constants and types for the clock divisor control block
// Assumes: 32-bit AXI4-Lite register bus, 16-bit control register in low bits
// Notes: Field positions follow the control register layout
package cdc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] CDC_OFS_CTRL = 4'h0;
  localparam logic [3:0] CDC_OFS_STAT = 4'h4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CDC_POS_ROI = 15;
  localparam int CDC_POS_RED_HI = 14;
  localparam int CDC_POS_RED_LO = 12;
  localparam int CDC_POS_EN = 11;
  localparam int CDC_POS_RC_HI = 10;
  localparam int CDC_POS_RC_LO = 8;
  localparam int CDC_POS_PLLO_HI = 7;
  localparam int CDC_POS_PLLO_LO = 6;
  localparam int CDC_POS_PRE_HI = 4;
  localparam int CDC_POS_PRE_LO = 0;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CDC_RST_RED = 3'h3;
  localparam logic [2:0] CDC_RST_RC = 3'h0;
  localparam logic [1:0] CDC_RST_PLLO = 2'h1;
  localparam logic [4:0] CDC_RST_PRE = 5'h00;
  localparam logic [2:0] CDC_RED_DIV1 = 3'h0;
  localparam logic [1:0] CDC_PLLO_RSVD = 2'h2;
  localparam logic [1:0] CDC_AXI_OKAY = 2'h0;
  localparam logic [1:0] CDC_AXI_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic recover_on_interrupt;
    logic [2:0] processor_clock_reduction_select;
    logic reduced_clock_enable;
    logic [2:0] rc_oscillator_postscaler;
    logic [1:0] pll_output_divider;
    logic [4:0] pll_input_prescaler;
  } cdc_ctrl_t;

  typedef struct packed {
    logic [8:0] rc_div;
    logic [7:0] cpu_div;
    logic [3:0] pll_div;
  } cdc_ratio_t;

  typedef enum logic [1:0] {
    CDC_W_IDLE,
    CDC_W_RESP
  } cdc_wstate_t;

endpackage

// *** src/cdc_ratio_reg.sv ***
// Purpose: Registered decode of control fields into division ratios
// Assumes: Fields come from the control register
// Notes: Outputs lag the fields by one clock
`timescale 1ns/10ps
module cdc_ratio_reg (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire cdc_pkg::cdc_ctrl_t ctrl,
  output cdc_pkg::cdc_ratio_t ratio
);
  import cdc_pkg::*;

  cdc_ratio_t ratio_reg;
  cdc_ratio_t ratio_next;

  function automatic logic [8:0] pow2_9(input logic [2:0] code);
    // 111 means 256, skipping 128
    if (code == 3'h7) begin
      pow2_9 = 9'h100;
    end else begin
      pow2_9 = 9'(1) << code;
    end
  endfunction

  always_comb begin
    ratio_next = ratio_reg;
    ratio_next.rc_div = pow2_9(ctrl.rc_oscillator_postscaler);
    // Ratio forced to 1 while reduction is off
    if (ctrl.reduced_clock_enable) begin
      ratio_next.cpu_div = 8'(1) << ctrl.processor_clock_reduction_select;
    end else begin
      ratio_next.cpu_div = 8'h01;
    end
    case (ctrl.pll_output_divider)
      2'h0: ratio_next.pll_div = 4'h2;
      2'h1: ratio_next.pll_div = 4'h4;
      2'h3: ratio_next.pll_div = 4'h8;
      default: ratio_next.pll_div = 4'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ratio_reg <= '0;
    end else if (ce) begin
      ratio_reg <= ratio_next;
    end
  end

  assign ratio = ratio_reg;
endmodule

// *** src/cdc_top.sv ***
// Purpose: Clock divisor control register with AXI4-Lite access
// Assumes: Interrupt input is a synchronous level or pulse on aclk
// Notes: Control register at 0x0, status at 0x4, others answer SLVERR
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps

// Functional notes
// - With recover set, an interrupt clears reduced clock enable; otherwise unchanged.
// - Reduction field picks CPU divide 1..128; reset value 011 means divide by 8.
// - Setting reduced clock enable is ignored while reduction field is 000.
// - RC postscaler field divides RC oscillator by 1,2,4,8,16,32,64,256.
// - PLL output divider: 00 by 2, 01 by 4, 11 by 8, 10 reserved.
module cdc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic irq_event,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output cdc_pkg::cdc_ctrl_t ctrl,
  output cdc_pkg::cdc_ratio_t ratio,
  output logic [2:0] cpu_clock_reduction_select
);
  import cdc_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    cdc_ctrl_t ctrl;
    logic aw_held;
    logic [3:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    cdc_wstate_t wst;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rsvd_seen;
  } cdc_state_t;

  cdc_state_t st_reg;
  cdc_state_t st_next;

  function automatic logic [15:0] ctrl_word(input cdc_ctrl_t c);
    ctrl_word = {c.recover_on_interrupt, c.processor_clock_reduction_select,
                 c.reduced_clock_enable, c.rc_oscillator_postscaler,
                 c.pll_output_divider, 1'b0, c.pll_input_prescaler};
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
    merge16 = old_v;
    if (be[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction

  localparam cdc_ctrl_t CDC_CTRL_RST = '{
    recover_on_interrupt: 1'b0,
    processor_clock_reduction_select: CDC_RST_RED,
    reduced_clock_enable: 1'b0,
    rc_oscillator_postscaler: CDC_RST_RC,
    pll_output_divider: CDC_RST_PLLO,
    pll_input_prescaler: CDC_RST_PRE
  };

  logic [15:0] cur_w;
  logic [15:0] new_w;
  logic [2:0] red_req;
  logic en_req;
  logic do_write;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    cur_w = ctrl_word(st_reg.ctrl);
    new_w = merge16(cur_w, st_reg.wdata, st_reg.wstrb);
    red_req = new_w[CDC_POS_RED_HI:CDC_POS_RED_LO];
    en_req = new_w[CDC_POS_EN];
    do_write = 1'b0;

    // Capture address and data independently
    if (s_axi_awvalid && !st_reg.aw_held && st_reg.wst == CDC_W_IDLE) begin
      st_next.aw_held = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_held && st_reg.wst == CDC_W_IDLE) begin
      st_next.w_held = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end

    case (st_reg.wst)
      CDC_W_IDLE: begin
        if (st_reg.aw_held && st_reg.w_held) begin
          st_next.aw_held = 1'b0;
          st_next.w_held = 1'b0;
          st_next.wst = CDC_W_RESP;
          if (st_reg.awaddr[3:2] == CDC_OFS_CTRL[3:2]) begin
            do_write = 1'b1;
            st_next.bresp = CDC_AXI_OKAY;
          end else if (st_reg.awaddr[3:2] == CDC_OFS_STAT[3:2]) begin
            st_next.bresp = CDC_AXI_OKAY;
          end else begin
            st_next.bresp = CDC_AXI_SLVERR;
          end
        end
      end
      CDC_W_RESP: begin
        if (s_axi_bready) begin
          st_next.wst = CDC_W_IDLE;
        end
      end
      default: begin
        st_next.wst = CDC_W_IDLE;
      end
    endcase

    if (do_write) begin
      st_next.ctrl.recover_on_interrupt = new_w[CDC_POS_ROI];
      st_next.ctrl.rc_oscillator_postscaler = new_w[CDC_POS_RC_HI:CDC_POS_RC_LO];
      st_next.ctrl.pll_input_prescaler = new_w[CDC_POS_PRE_HI:CDC_POS_PRE_LO];
      // Reserved divider code kept out of the register
      if (new_w[CDC_POS_PLLO_HI:CDC_POS_PLLO_LO] != CDC_PLLO_RSVD) begin
        st_next.ctrl.pll_output_divider = new_w[CDC_POS_PLLO_HI:CDC_POS_PLLO_LO];
      end else begin
        st_next.rsvd_seen = 1'b1;
      end
      // Field frozen while reduction is active
      if (!st_reg.ctrl.reduced_clock_enable) begin
        st_next.ctrl.processor_clock_reduction_select = red_req;
      end
      if (!en_req) begin
        st_next.ctrl.reduced_clock_enable = 1'b0;
      end else if (st_next.ctrl.processor_clock_reduction_select != CDC_RED_DIV1) begin
        st_next.ctrl.reduced_clock_enable = 1'b1;
      end
    end

    // Interrupt wins over a same-cycle write
    if (irq_event && st_reg.ctrl.recover_on_interrupt) begin
      st_next.ctrl.reduced_clock_enable = 1'b0;
    end

    // Read channel
    if (st_reg.rvalid) begin
      if (s_axi_rready) begin
        st_next.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = CDC_AXI_OKAY;
      if (s_axi_araddr[3:2] == CDC_OFS_CTRL[3:2]) begin
        st_next.rdata = {16'h0000, cur_w};
      end else if (s_axi_araddr[3:2] == CDC_OFS_STAT[3:2]) begin
        st_next.rdata = {31'h0000_0000, st_reg.rsvd_seen};
        // A reserved code landing in the same cycle stays flagged
        st_next.rsvd_seen = do_write &&
                            new_w[CDC_POS_PLLO_HI:CDC_POS_PLLO_LO] == CDC_PLLO_RSVD;
      end else begin
        st_next.rdata = 32'h0000_0000;
        st_next.rresp = CDC_AXI_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.ctrl <= CDC_CTRL_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = ce && !st_reg.aw_held && st_reg.wst == CDC_W_IDLE;
  assign s_axi_wready = ce && !st_reg.w_held && st_reg.wst == CDC_W_IDLE;
  assign s_axi_bvalid = st_reg.wst == CDC_W_RESP;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = ce && !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign ctrl = st_reg.ctrl;
  assign cpu_clock_reduction_select = st_reg.ctrl.processor_clock_reduction_select;

  cdc_ratio_reg u_ratio (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .ctrl(st_reg.ctrl),
    .ratio(ratio)
  );
endmodule

// *** bench/cdc_top_props.sv ***
// Purpose: Port checks for the clock divisor control block
// Assumes: One clock, synchronous active-low reset
// Notes: Ratio checks compare against the fields of the cycle before
`timescale 1ns/10ps
module cdc_top_props
  import cdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic irq_event,
  input wire logic s_axi_bvalid,
  input wire cdc_pkg::cdc_ctrl_t ctrl,
  input wire cdc_pkg::cdc_ratio_t ratio,
  input wire logic [2:0] cpu_clock_reduction_select
);
  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  wire en = ctrl.reduced_clock_enable;
  wire [2:0] red = ctrl.processor_clock_reduction_select;
  wire [2:0] rc = ctrl.rc_oscillator_postscaler;
  wire [1:0] pll = ctrl.pll_output_divider;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_irq_clears_en:
    assert property (ce && irq_event && ctrl.recover_on_interrupt |=> !en)
    else $error("enable survived irq");
  a_irq_keeps_en:
    assert property (ce && irq_event && !ctrl.recover_on_interrupt && en
      |=> en || $rose(s_axi_bvalid)) else $error("enable lost on irq");
  a_no_en_div1:
    assert property (red == CDC_RED_DIV1 |-> !en) else $error("enable with code 000");
  a_cpu_ratio:
    assert property (ce |=> ratio.cpu_div ==
      ($past(en) ? 8'h01 << $past(red) : 8'h01)) else $error("cpu ratio wrong");
  a_rc_ratio:
    assert property (ce |=> ratio.rc_div ==
      ($past(rc) == 3'h7 ? 9'h100 : 9'h001 << $past(rc))) else $error("rc ratio wrong");
  a_pll_ratio:
    assert property (ce |=> ratio.pll_div ==
      ($past(pll) == 2'h3 ? 4'h8 : 4'h2 << $past(pll))) else $error("pll ratio wrong");
  a_pll_no_rsvd:
    assert property (pll != CDC_PLLO_RSVD) else $error("reserved pll code held");
  a_red_frozen:
    assert property (en |=> $stable(red)) else $error("reduction moved while enabled");
  a_sel_mirror:
    assert property (cpu_clock_reduction_select == red) else $error("select port differs");
  c_irq: cover property (ce && irq_event && ctrl.recover_on_interrupt);
  c_write: cover property ($rose(s_axi_bvalid));
  c_div32: cover property (en && ratio.cpu_div == 8'h20);
endmodule
bind cdc_top cdc_top_props i_cdc_top_props (
  .aclk, .aresetn, .ce, .irq_event, .s_axi_bvalid,
  .ctrl, .ratio, .cpu_clock_reduction_select
);

// *** bench/test_cdc_top.sv ***
// Purpose: Self-checking bench for the clock divisor control block
// Assumes: ce and wstrb high except in their own scenarios
// Notes: Answers are captured at the falling edge before the taking edge
`timescale 1ns/10ps
module test_cdc_top;
  import cdc_pkg::*;
  logic aclk = '0, aresetn = '0, ce = '1, irq_event = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  cdc_ctrl_t ctrl;
  cdc_ratio_t ratio;
  logic [2:0] cpu_clock_reduction_select;
  int fail_count = 0;
  int checks = 0;
  always #12.5 aclk = ~aclk;
  cdc_top i_cdc_top (
    .aclk, .aresetn, .ce, .irq_event, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctrl, .ratio, .cpu_clock_reduction_select
  );
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d fails %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] cw(logic r, logic [2:0] d, logic e, logic [2:0] c,
                                     logic [1:0] p);
    return {16'h0000, r, d, e, c, p, 6'h00};
  endfunction
  // One write (w=1) or read; d is write data or expected read data
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    logic ta, tw, tr, tb;
    logic [31:0] q;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      tb = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= '0;
      if (tw) s_axi_wvalid <= '0;
      if (tr) s_axi_arvalid <= '0;
      if (tb) break;
    end
    s_axi_bready <= '0;
    s_axi_rready <= '0;
    if (!tb) begin
      fail_count++;
      results();
    end
    if (!w) chk("rdata", q, d);
    chk("resp", r, e);
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= '1;
    acc(0, CDC_OFS_CTRL, 32'h0000_3040, CDC_AXI_OKAY);
    chk("ratio", ratio, {9'h001, 8'h01, 4'h4});
    acc(0, 4'h8, '0, CDC_AXI_SLVERR);
    acc(1, 4'hC, '0, CDC_AXI_SLVERR);
    acc(1, CDC_OFS_CTRL, cw(0, 0, 1, 0, 1), CDC_AXI_OKAY);
    acc(0, CDC_OFS_CTRL, cw(0, 0, 0, 0, 1), CDC_AXI_OKAY);
    for (int i = 0; i < 8; i++) begin
      acc(1, CDC_OFS_CTRL, cw(0, i[2:0], 1, i[2:0], 1), CDC_AXI_OKAY);
      @(negedge aclk);
      chk("rc_div", ratio.rc_div, i == 7 ? 256 : 1 << i);
      chk("cpu_div", ratio.cpu_div, 1 << i);
      acc(1, CDC_OFS_CTRL, cw(0, ~i[2:0], 0, i[2:0], 1), CDC_AXI_OKAY);
      acc(0, CDC_OFS_CTRL, cw(0, i == 0 ? 3'h7 : i[2:0], 0, i[2:0], 1), CDC_AXI_OKAY);
      chk("cpu_1to1", ratio.cpu_div, 1);
      chk("red_sel", cpu_clock_reduction_select, i == 0 ? 7 : i);
    end
    for (int j = 0; j < 4; j++) begin
      acc(1, CDC_OFS_CTRL, cw(0, 3, 0, 0, j[1:0]), CDC_AXI_OKAY);
      @(negedge aclk);
      chk("pll_div", ratio.pll_div, j == 3 ? 8 : j == 2 ? 4 : 2 << j);
      acc(0, CDC_OFS_STAT, j == 2, CDC_AXI_OKAY);
    end
    // Only the low byte lane lands: pll field moves, upper fields stay
    s_axi_wstrb <= 4'h1;
    acc(1, CDC_OFS_CTRL, cw(1, 5, 1, 7, 0), CDC_AXI_OKAY);
    s_axi_wstrb <= '1;
    acc(0, CDC_OFS_CTRL, cw(0, 3, 0, 0, 0), CDC_AXI_OKAY);
    for (int r = 1; r >= 0; r--) begin
      acc(1, CDC_OFS_CTRL, cw(r[0], 3, 1, 0, 1), CDC_AXI_OKAY);
      irq_event <= '1;
      @(posedge aclk);
      irq_event <= '0;
      @(negedge aclk);
      chk("enable", ctrl.reduced_clock_enable, !r[0]);
    end
    // Clock enable low freezes state and refuses the bus
    acc(1, CDC_OFS_CTRL, cw(1, 3, 1, 0, 1), CDC_AXI_OKAY);
    ce <= '0;
    irq_event <= '1;
    repeat (2) @(posedge aclk);
    chk("frozen_en", ctrl.reduced_clock_enable, 1);
    chk("frozen_awready", s_axi_awready, 0);
    ce <= '1;
    @(posedge aclk);
    irq_event <= '0;
    @(negedge aclk);
    chk("enable_ce", ctrl.reduced_clock_enable, 0);
    results();
  end
endmodule
